// ==== core/ccx_alu.v ====
`timescale 1ns/1ps
// ****************************************
// Compare subtractor: flags from dst - src at byte or word size
// ****************************************
module ccx_alu
(
  input  wire [15:0] dst,      // Destination operand
  input  wire [15:0] src,      // Source operand
  input  wire        byte_sz,  // High for byte compare
  output wire [3:0]  flags     // Z N C V
);
  wire [16:0] dw;             // Word difference with borrow
  wire [8:0]  db;             // Byte difference with borrow
  wire        zw;             // Word zero
  wire        zb;             // Byte zero
  wire        vw;             // Word signed underflow
  wire        vb;             // Byte signed underflow

  // Both widths computed; byte uses low bytes only
  assign dw = {1'b0, dst} - {1'b0, src};
  assign db = {1'b0, dst[7:0]} - {1'b0, src[7:0]};
  assign zw = (dw[15:0] == 16'h0000);
  assign zb = (db[7:0] == 8'h00);
  assign vw = (dst[15] ^ src[15]) & (dst[15] ^ dw[15]);
  assign vb = (dst[7] ^ src[7]) & (dst[7] ^ db[7]);
  // Z, N from bit 7 or 15, C borrow, V signed underflow
  assign flags = byte_sz ? {zb, db[7], db[8], vb} : {zw, dw[15], dw[16], vw};
endmodule // ccx_alu

// ==== core/ccx_core.v ====
// Local design decisions: the register offsets and strobed register access.
`timescale 1ns/1ps
`include "ccx_regs.vh"
// How it works
// - Bit selector is opcode upper-byte low three bits
// - Call pushes return, bumps SP, loads PC
// - Return is opcode address plus 2/4, halved
// - Absolute target drives address lines A16-A1
// - Register call loads register into PC
// - Indirect call reads target word at reg+disp
// - Fetch address is PC shifted, A0 low
// - Call leaves all four flags alone
// - Clear writes zero; registers fully zeroed
// - Clear sets Z, clears N, V, keeps C
// - Post-increment clear bumps register by 1/2
// - Compare subtracts, updates flags, discards result
// - Flags: zero, sign bit, borrow, signed underflow
// - Byte compares use low bytes only
// - Same-register compare happens before increment
module ccx_core
(
  input  wire        clk_sys,   // System clock, 20 MHz
  input  wire        rstn,      // Asynchronous reset, active low
  output reg  [16:0] mem_addr,  // Byte address bus A16..A0
  output reg  [15:0] mem_wdata, // Write data
  output reg         mem_rd,    // Read strobe
  output reg         mem_wr,    // Write strobe
  output reg         mem_byte,  // Byte-sized access
  input  wire [15:0] mem_rdata, // Read data, sampled at the edge ending the mem_rd cycle
  output reg  [15:0] pc_q,      // Program counter, word address
  output reg  [15:0] sp_q,      // Stack pointer
  output reg  [3:0]  flags_q,   // Condition flag register Z N C V
  output reg  [2:0]  bit_sel_q, // Bit number for branch_if_bit_set
  output reg         busy_q     // Instruction in progress
);
  // ****************************************
  // States
  // ****************************************
  localparam [3:0] S_FETCH  = 4'h0;  // Fetch opcode word
  localparam [3:0] S_DEC    = 4'h1;  // Latch opcode word
  localparam [3:0] S_EXT1   = 4'h2;  // Fetch first extension word
  localparam [3:0] S_EXT1W  = 4'h3;  // Latch first extension word
  localparam [3:0] S_EXT2W  = 4'h4;  // Latch second extension word
  localparam [3:0] S_OPA    = 4'h5;  // Latch first memory operand, read second
  localparam [3:0] S_OPAW   = 4'h6;  // Latch first memory operand
  localparam [3:0] S_OPBW   = 4'h7;  // Latch second memory operand
  localparam [3:0] S_PUSH   = 4'h8;  // Push return address
  localparam [3:0] S_TGTW   = 4'h9;  // Latch indirect call target
  localparam [3:0] S_CLRW   = 4'ha;  // Write zero to memory

  reg [3:0]  st_q;              // Current state
  reg [15:0] gpr_q [0:15];      // General registers, entry 15 reads zero
  reg [15:0] op_q;              // Current opcode word
  reg [16:0] opa_q;             // Opcode byte address
  reg [15:0] ext1_q;            // First extension word
  reg [15:0] ext2_q;            // Second extension word
  reg [15:0] srcv_q;            // Latched source operand
  reg [15:0] dstv_q;            // Latched destination operand
  reg [16:0] ret_q;             // Return byte address
  wire [7:0] ohi;               // Opcode upper byte
  wire [3:0] rs;                // Source register field
  wire [3:0] rd;                // Destination register field
  wire       bsz;               // Byte size select
  wire [3:0] cmp_flags;         // Compare flags from subtractor
  integer    i;                 // Register reset index

  assign ohi = op_q[15:8];
  assign rs  = op_q[7:4];
  assign rd  = op_q[3:0];
  assign bsz = ohi[0];          // Odd upper byte means byte

  // ****************************************
  // Helpers
  // ****************************************
  // Register read with hard-wired zero register
  function [15:0] rreg;
    input [3:0] n;
    begin
      rreg = (n == `CCX_ZERO_REG) ? 16'h0000 : gpr_q[n];
    end
  endfunction

  // Word address to bus byte address, A0 forced low
  function [16:0] w2b;
    input [15:0] w;
    begin
      w2b = {w, 1'b0};
    end
  endfunction

  ccx_alu u_alu
  (
    .dst     (dstv_q),
    .src     (srcv_q),
    .byte_sz (bsz),
    .flags   (cmp_flags)
  );

  // ****************************************
  // Sequencer
  // ****************************************
  always @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      st_q      <= S_FETCH;
      pc_q      <= `CCX_PC_RST;
      sp_q      <= `CCX_SP_RST;
      flags_q   <= 4'h0;
      bit_sel_q <= 3'h0;
      busy_q    <= 1'b0;
      op_q      <= 16'h0000;
      opa_q     <= 17'h00000;
      ext1_q    <= 16'h0000;
      ext2_q    <= 16'h0000;
      srcv_q    <= 16'h0000;
      dstv_q    <= 16'h0000;
      ret_q     <= 17'h00000;
      mem_addr  <= 17'h00000;
      mem_wdata <= 16'h0000;
      mem_rd    <= 1'b0;
      mem_wr    <= 1'b0;
      mem_byte  <= 1'b0;
      for (i = 0; i < 16; i = i + 1)
        gpr_q[i] <= 16'h0000;
    end
    else
    begin
      mem_rd <= 1'b0;
      mem_wr <= 1'b0;
      case (st_q)
        S_FETCH:
        begin
          // Opcode fetch at PC word address
          mem_addr <= w2b(pc_q);
          mem_byte <= 1'b0;
          mem_rd   <= 1'b1;
          opa_q    <= w2b(pc_q);
          pc_q     <= pc_q + 16'h0001;
          busy_q   <= 1'b1;
          st_q     <= S_DEC;
        end
        S_DEC:
        begin
          // Opcode data arrives this cycle
          op_q <= mem_rdata;
          st_q <= S_EXT1;
        end
        S_EXT1:
        begin
          // Decode and fetch extension when needed
          if (ohi[7:3] == `CCX_OP_BRANCH_IF_BIT_SET_HI)
          begin
            bit_sel_q <= ohi[2:0];
            st_q      <= S_FETCH;
            busy_q    <= 1'b0;
          end
          else if (ohi == `CCX_OP_CALL_REG)
          begin
            ret_q <= opa_q + `CCX_RET_SHORT;
            st_q  <= S_PUSH;
          end
          else if (ohi == `CCX_OP_CALL_ABS || ohi == `CCX_OP_CALL_IND ||
                   ohi[7:1] == `CCX_OP_CLR_DISP || ohi[7:1] == `CCX_OP_CMP_IMM ||
                   ohi[7:1] == `CCX_OP_CMP_DISP || ohi[7:1] == `CCX_OP_CMP_DD)
          begin
            mem_addr <= w2b(pc_q);
            mem_byte <= 1'b0;
            mem_rd   <= 1'b1;
            pc_q     <= pc_q + 16'h0001;
            ret_q    <= opa_q + `CCX_RET_LONG;
            st_q     <= S_EXT1W;
          end
          else if (ohi[7:1] == `CCX_OP_CLR_REG)
          begin
            // Whole register zeroed even for byte size
            if (rd != `CCX_ZERO_REG)
              gpr_q[rd] <= rreg(`CCX_ZERO_REG);
            flags_q[`CCX_FLAG_Z] <= 1'b1;
            flags_q[`CCX_FLAG_N] <= 1'b0;
            flags_q[`CCX_FLAG_V] <= 1'b0;
            st_q   <= S_FETCH;
            busy_q <= 1'b0;
          end
          else if (ohi[7:1] == `CCX_OP_CLR_IND || ohi[7:1] == `CCX_OP_CLR_POST)
          begin
            mem_addr  <= {1'b0, rreg(rd)};
            st_q      <= S_CLRW;
          end
          else if (ohi[7:1] == `CCX_OP_CMP_RR)
          begin
            srcv_q <= rreg(rs);
            dstv_q <= rreg(rd);
            st_q   <= S_OPBW;
          end
          else if (ohi[7:1] == `CCX_OP_CMP_POST)
          begin
            // Operand read through unincremented register
            mem_addr <= {1'b0, rreg(rs)};
            mem_byte <= bsz;
            mem_rd   <= 1'b1;
            dstv_q   <= rreg(rd);
            st_q     <= S_OPAW;
          end
          else
          begin
            // Other opcodes belong elsewhere; skip
            st_q   <= S_FETCH;
            busy_q <= 1'b0;
          end
        end
        S_EXT1W:
        begin
          ext1_q <= mem_rdata;
          if (ohi == `CCX_OP_CALL_ABS || ohi == `CCX_OP_CALL_IND)
            st_q <= S_PUSH;
          else if (ohi[7:1] == `CCX_OP_CLR_DISP)
          begin
            mem_addr <= {1'b0, mem_rdata + rreg(rd)};
            st_q     <= S_CLRW;
          end
          else if (ohi[7:1] == `CCX_OP_CMP_IMM)
          begin
            srcv_q <= mem_rdata;
            dstv_q <= rreg(rd);
            st_q   <= S_OPBW;
          end
          else if (ohi[7:1] == `CCX_OP_CMP_DISP)
          begin
            mem_addr <= {1'b0, mem_rdata + rreg(rs)};
            mem_byte <= bsz;
            mem_rd   <= 1'b1;
            dstv_q   <= rreg(rd);
            st_q     <= S_OPAW;
          end
          else
          begin
            // Two-displacement compare: second word next
            mem_addr <= w2b(pc_q);
            mem_byte <= 1'b0;
            mem_rd   <= 1'b1;
            pc_q     <= pc_q + 16'h0001;
            st_q     <= S_EXT2W;
          end
        end
        S_EXT2W:
        begin
          ext2_q   <= mem_rdata;
          mem_addr <= {1'b0, ext1_q + rreg(rs)};
          mem_byte <= bsz;
          mem_rd   <= 1'b1;
          st_q     <= S_OPA;
        end
        S_OPA:
        begin
          // Source latched; read destination memory operand
          srcv_q   <= bsz ? {8'h00, mem_rdata[7:0]} : mem_rdata;
          mem_addr <= {1'b0, ext2_q + rreg(rd)};
          mem_rd   <= 1'b1;
          st_q     <= S_OPBW;
          dstv_q   <= 16'h0000;
          ret_q    <= 17'h1ffff;   // Marks destination pending
        end
        S_OPAW:
        begin
          srcv_q <= bsz ? {8'h00, mem_rdata[7:0]} : mem_rdata;
          st_q   <= S_OPBW;
        end
        S_OPBW:
        begin
          if (ohi[7:1] == `CCX_OP_CMP_DD && ret_q == 17'h1ffff)
          begin
            dstv_q <= bsz ? {8'h00, mem_rdata[7:0]} : mem_rdata;
            ret_q  <= 17'h00000;
          end
          else
          begin
            // Flags from difference, operands untouched
            flags_q <= cmp_flags;
            // Increment only after the compare
            if (ohi[7:1] == `CCX_OP_CMP_POST && rs != `CCX_ZERO_REG)
              gpr_q[rs] <= gpr_q[rs] + (bsz ? 16'h0001 : 16'h0002);
            st_q   <= S_FETCH;
            busy_q <= 1'b0;
          end
        end
        S_PUSH:
        begin
          // Push return word, bump SP; flags untouched
          mem_addr  <= {1'b0, sp_q};
          mem_wdata <= ret_q[16:1];
          mem_byte  <= 1'b0;
          mem_wr    <= 1'b1;
          sp_q      <= sp_q + `CCX_SP_STEP;
          if (ohi == `CCX_OP_CALL_REG)
          begin
            pc_q   <= rreg(rd);
            st_q   <= S_FETCH;
            busy_q <= 1'b0;
          end
          else if (ohi == `CCX_OP_CALL_ABS)
          begin
            pc_q   <= ext1_q;
            st_q   <= S_FETCH;
            busy_q <= 1'b0;
          end
          else
            st_q <= S_TGTW;
        end
        S_TGTW:
        begin
          // Issue the pointer read at disp + register
          if (!mem_rd)
          begin
            mem_addr <= {1'b0, ext1_q + rreg(rd)};
            mem_rd   <= 1'b1;
          end
          else
          begin
            pc_q   <= mem_rdata;
            st_q   <= S_FETCH;
            busy_q <= 1'b0;
          end
        end
        S_CLRW:
        begin
          // Zero to memory, then post-increment
          mem_wdata <= rreg(`CCX_ZERO_REG);
          mem_byte  <= bsz;
          mem_wr    <= 1'b1;
          if (ohi[7:1] == `CCX_OP_CLR_POST && rd != `CCX_ZERO_REG)
            gpr_q[rd] <= gpr_q[rd] + (bsz ? 16'h0001 : 16'h0002);
          flags_q[`CCX_FLAG_Z] <= 1'b1;
          flags_q[`CCX_FLAG_N] <= 1'b0;
          flags_q[`CCX_FLAG_V] <= 1'b0;
          st_q   <= S_FETCH;
          busy_q <= 1'b0;
        end
        default:
        begin
          st_q <= S_FETCH;
        end
      endcase
    end
  end
endmodule // ccx_core

// ==== core/ccx_regs.vh ====
`ifndef CCX_REGS_VH
`define CCX_REGS_VH
// ****************************************
// Opcode upper-byte codes
// ****************************************
`define CCX_OP_CALL_REG   8'heb
`define CCX_OP_CALL_ABS   8'hec
`define CCX_OP_CALL_IND   8'hed
`define CCX_OP_CLR_REG    7'h01
`define CCX_OP_CLR_IND    7'h02
`define CCX_OP_CLR_POST   7'h03
`define CCX_OP_CLR_DISP   7'h04
`define CCX_OP_CMP_RR     7'h30
`define CCX_OP_CMP_IMM    7'h31
`define CCX_OP_CMP_DISP   7'h32
`define CCX_OP_CMP_POST   7'h33
`define CCX_OP_CMP_DD     7'h34
`define CCX_OP_BRANCH_IF_BIT_SET_HI  5'h1a
// ****************************************
// Flag positions in the condition flag register
// ****************************************
`define CCX_FLAG_Z        3
`define CCX_FLAG_N        2
`define CCX_FLAG_C        1
`define CCX_FLAG_V        0
// ****************************************
// Reset values and steps
// ****************************************
`define CCX_PC_RST        16'h0000
`define CCX_SP_RST        16'h0000
`define CCX_SP_STEP       16'h0002
`define CCX_RET_SHORT     17'h00002
`define CCX_RET_LONG      17'h00004
`define CCX_ZERO_REG      4'hf
`endif

// ==== tb/call_clear_compare_exec_test.sv ====
`timescale 1ns/1ps
module call_clear_compare_exec_test;
  // ****
  // Case table: program words, aux word, expected state
  // ****
  typedef struct packed
  {
    logic [63:0] w;  // Words 0..3
    logic [15:0] ax; // Aux word index
    logic [15:0] ad; // Aux word value
    logic [15:0] sp; // Expected stack pointer
    logic [3:0]  fl; // Expected flags
    logic [3:0]  bs; // Expected bit selector
    logic [3:0]  mi; // Memory word to check
    logic [15:0] mv; // Its expected value
  } ccx_row_t;
  ccx_row_t    rows [0:13]; // Cases
  logic        clk_sys;     // Clock
  logic        rstn;        // Reset, active low
  wire  [16:0] mem_addr;    // Byte address
  wire  [15:0] mem_wdata;   // Write data
  wire         mem_rd;      // Read strobe
  wire         mem_wr;      // Write strobe
  wire         mem_byte;    // Byte access
  wire  [15:0] mem_rdata;   // Read data
  wire  [15:0] pc_q;        // Program counter
  wire  [15:0] sp_q;        // Stack pointer
  wire  [3:0]  flags_q;     // Flags
  wire  [2:0]  bit_sel_q;   // Bit selector
  wire         busy_q;      // Busy
  int          errors;      // Mismatches
  int          n_checks;    // Comparisons
  int          cyc;         // Cycle count
  ccx_core DUT (.clk_sys(clk_sys), .rstn(rstn), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_byte(mem_byte), .mem_rdata(mem_rdata),
    .pc_q(pc_q), .sp_q(sp_q), .flags_q(flags_q), .bit_sel_q(bit_sel_q), .busy_q(busy_q));
  ccx_mem_model mdl (.clk_sys(clk_sys), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_byte(mem_byte), .mem_rdata(mem_rdata));
  // 20 MHz clock
  initial
  begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  // Cut a hang short
  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    if (cyc == 8000)
    begin
      errors = errors + 1;
      $display("FAIL %0t timeout", $time);
      test_done;
    end
  end
  // ****
  // Tasks
  // ****
  task chk(input logic [15:0] got, input logic [15:0] exp);
    begin
      n_checks++;
      if (got !== exp)
      begin
        errors++;
        $display("FAIL %0t got %h want %h", $time, got, exp);
      end
    end
  endtask
  // Reset, load program, run until SP and bit selector match the row
  task run_row(input ccx_row_t r, input int k);
    int w;
    begin
      rstn <= 1'b0;
      @(posedge clk_sys);
      mdl.fill;
      mdl.mem[0] = r.w[63:48];
      mdl.mem[1] = r.w[47:32];
      mdl.mem[2] = r.w[31:16];
      mdl.mem[3] = r.w[15:0];
      mdl.mem[r.ax] = r.ad;
      @(posedge clk_sys);
      rstn <= 1'b1;
      w = 0;
      while (!(sp_q === r.sp && bit_sel_q === r.bs[2:0]) && w < 300)
      begin
        @(posedge clk_sys);
        w++;
      end
      repeat (3) @(posedge clk_sys);
      @(negedge clk_sys);
      chk(sp_q, r.sp);
      chk({12'h000, flags_q}, {12'h000, r.fl});
      chk({13'h0000, bit_sel_q}, {13'h0000, r.bs[2:0]});
      chk(mdl.mem[r.mi], r.mv);
      $display("test %0d done", k);
      @(posedge clk_sys);
    end
  endtask
  task test_done;
    begin
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  // ****
  // Main sequence
  // ****
  initial
  begin
    rstn = 1'b0;
    errors = 0;
    n_checks = 0;
    cyc = 0;
    rows[0] = 140'hffff_ec00_0100_ffff_0100_d500_0002_0_5_0_0003;
    rows[1] = 140'h06f1_06f1_06f1_eb01_0006_d300_0002_8_3_0_0004;
    rows[2] = 140'hed00_0006_ffff_0100_0100_d600_0002_0_6_0_0002;
    rows[3] = 140'hec00_0003_ffff_ed00_0004_0008_0004_0_0_1_0005;
    rows[4] = 140'h6200_0001_d700_ffff_0200_ffff_0000_6_7_0_6200;
    rows[5] = 140'h6300_0100_d600_ffff_0200_ffff_0000_8_6_0_6300;
    rows[6] = 140'h06f1_6201_8002_d200_0200_ffff_0000_7_2_0_0000;
    rows[7] = 140'h0000_6611_d400_ffff_0200_ffff_0000_8_4_1_6611;
    rows[8] = 140'h0000_6611_6201_0002_0004_d400_0000_8_4_0_0000;
    rows[9] = 140'h07f1_07f1_6201_0002_0004_d100_0000_8_1_0_0000;
    rows[10] = 140'h06f1_03f1_6201_0000_0004_d600_0000_8_6_0_0000;
    rows[11] = 140'h06f1_04f1_601f_d500_0200_ffff_0000_6_5_1_0000;
    rows[12] = 140'h08f0_000a_650f_0001_0004_d300_0000_2_3_5_0000;
    rows[13] = 140'h6801_0000_0002_d100_0200_ffff_0000_6_1_0_6801;
    repeat (2) @(posedge clk_sys);
    for (int i = 0; i < 14; i++)
      run_row(rows[i], i);
    // Reset in mid-run clears state, then fetch restarts at byte 0
    rstn <= 1'b0;
    @(posedge clk_sys);
    #1;
    chk({pc_q[15:0]}, 16'h0000);
    chk({15'h0000, busy_q}, 16'h0000);
    chk({12'h000, flags_q}, 16'h0000);
    @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
    #1;
    chk({15'h0000, mem_rd}, 16'h0001);
    chk(mem_addr[15:0], 16'h0000);
    $display("test reset done");
    test_done;
  end
endmodule // call_clear_compare_exec_test

// ==== tb/ccx_core_assertions.sv ====
`timescale 1ns/1ps
`include "ccx_regs.vh"
module ccx_checker
(
  input wire        clk_sys,   // System clock
  input wire        rstn,      // Reset, active low
  input wire [16:0] mem_addr,  // Byte address
  input wire [15:0] mem_wdata, // Write data
  input wire        mem_rd,    // Read strobe
  input wire        mem_wr,    // Write strobe
  input wire        mem_byte,  // Byte access
  input wire [15:0] mem_rdata, // Read data
  input wire [15:0] pc_q,      // Program counter
  input wire [15:0] sp_q,      // Stack pointer
  input wire [3:0]  flags_q,   // Z N C V
  input wire [2:0]  bit_sel_q, // Bit selector
  input wire        busy_q     // Busy
);
  // ****
  // Helper: last word returned by memory
  // ****
  reg [15:0] op_q;  // Last returned word
  wire [7:0] op_hi; // Its upper byte
  wire [7:0] sel_c; // Opcode that would select bit_sel_q
  assign op_hi = op_q[15:8];
  assign sel_c = {`CCX_OP_BRANCH_IF_BIT_SET_HI, bit_sel_q};
  // Capture read data at the edge that ends the strobe cycle
  always @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      op_q <= 16'h0000;
    else if (mem_rd)
      op_q <= mem_rdata;
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  // ****
  // Properties
  // ****
  sp_step_a: assert property ($changed(sp_q) |-> sp_q == $past(sp_q) + 16'h0002)
    else $error("stack pointer step wrong");
  call_flags_a: assert property ($changed(sp_q) |-> $stable(flags_q))
    else $error("call touched flags");
  push_place_a: assert property (mem_wr && mem_wdata != 16'h0000 |->
    mem_addr == {1'b0, sp_q - 16'h0002})
    else $error("push not at stack pointer");
  fetch_next_a: assert property ($fell(busy_q) |=> mem_rd && busy_q && !mem_addr[0])
    else $error("no fetch after instruction end");
  word_align_a: assert property (mem_rd && !mem_byte |-> !mem_addr[0])
    else $error("word read at odd address");
  zero_flags_a: assert property (flags_q[3] |-> !flags_q[2] && !flags_q[0])
    else $error("zero flag with sign or overflow");
  byte_clear_a: assert property (mem_wr && mem_byte |-> mem_wdata == 16'h0000)
    else $error("byte write not zero");
  bit_sel_a: assert property ($changed(bit_sel_q) |-> op_hi == sel_c ||
    $past(op_hi) == sel_c || $past(op_hi, 2) == sel_c || $past(op_hi, 3) == sel_c)
    else $error("bit selector without opcode");
  call_fetch_a: assert property ($changed(sp_q) |-> ##[1:6] mem_rd &&
    (mem_addr == {pc_q, 1'b0} || mem_addr == {$past(pc_q), 1'b0}))
    else $error("no fetch at program counter");
  cover property ($changed(sp_q));
  cover property (mem_wr && mem_byte);
  cover property ($changed(bit_sel_q));
endmodule // ccx_checker

bind ccx_core ccx_checker u_chk (.clk_sys(clk_sys), .rstn(rstn), .mem_addr(mem_addr),
  .mem_wdata(mem_wdata), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_byte(mem_byte),
  .mem_rdata(mem_rdata), .pc_q(pc_q), .sp_q(sp_q), .flags_q(flags_q),
  .bit_sel_q(bit_sel_q), .busy_q(busy_q));

// ==== tb/ccx_mem_model.sv ====
`timescale 1ns/1ps
module ccx_mem_model
(
  input  wire        clk_sys,   // System clock
  input  wire [16:0] mem_addr,  // Byte address
  input  wire [15:0] mem_wdata, // Write data
  input  wire        mem_rd,    // Read strobe
  input  wire        mem_wr,    // Write strobe
  input  wire        mem_byte,  // Byte access
  output wire [15:0] mem_rdata  // Read data, while the read strobe stands
);
  reg  [15:0] mem [0:65535]; // Word store
  wire [15:0] word_rd;       // Word at the bus address
  wire [15:0] rd_val;        // Word, or addressed byte in the low lane
  integer     i;             // Fill index
  // Unknown opcode everywhere, so stray fetches do nothing
  task fill;
    begin
      for (i = 0; i < 65536; i = i + 1)
        mem[i] = 16'hffff;
    end
  endtask
  // A byte read hands the addressed byte back in the low lane
  assign word_rd = mem[mem_addr[16:1]];
  assign rd_val  = !mem_byte ? word_rd :
                   mem_addr[0] ? {8'h00, word_rd[7:0]} : {8'h00, word_rd[15:8]};
  // Core samples at the edge ending the strobe cycle; inverted data elsewhere
  assign mem_rdata = mem_rd ? rd_val : ~rd_val;
  // Writes land at the edge that ends the strobe cycle
  always @(posedge clk_sys)
  begin
    // Even byte is the upper lane
    if (mem_wr && !mem_byte)
      mem[mem_addr[16:1]] <= mem_wdata;
    else if (mem_wr && mem_addr[0])
      mem[mem_addr[16:1]][7:0] <= mem_wdata[7:0];
    else if (mem_wr)
      mem[mem_addr[16:1]][15:8] <= mem_wdata[15:8];
  end
endmodule // ccx_mem_model
